// ---- design/srseq_pkg.sv ----
// Shared constants and types for the supply rail sequencer and its host
package srseq_pkg;
   localparam int SRSEQ_OUTS = 4;
   localparam int SRSEQ_DRV_W = 16;
   localparam int SRSEQ_CNT_W = 16;
   // Step time from an internal 100 kohm and the external capacitor
   localparam real SRSEQ_R_KOHM = 100.0;
   localparam real SRSEQ_CAP_NF = 1.0;
   localparam real SRSEQ_LN2 = 0.6931471805599453;
   localparam real SRSEQ_CLK_NS = 10.0;
   // kohm * nF = us; times 1000 for ns
   localparam real SRSEQ_TSTEP_NS = 2.0 * SRSEQ_LN2 * SRSEQ_R_KOHM * SRSEQ_CAP_NF * 1000.0;
   localparam int SRSEQ_STEP_CYC = int'(SRSEQ_TSTEP_NS / SRSEQ_CLK_NS);
   localparam logic [SRSEQ_OUTS-1:0] SRSEQ_ALL_OFF = 4'h0;
   localparam logic [SRSEQ_OUTS-1:0] SRSEQ_ALL_ON = 4'hF;
   typedef enum logic [3:0]
   {
      SRSEQ_OFF = 4'h1,
      SRSEQ_RISE = 4'h2,
      SRSEQ_ON = 4'h4,
      SRSEQ_FALL = 4'h8
   } srseq_state_t;
   typedef enum logic [4:0]
   {
      SRSEQ_H_IDLE = 5'h01,
      SRSEQ_H_WAIT_ON = 5'h02,
      SRSEQ_H_UP = 5'h04,
      SRSEQ_H_WAIT_OFF = 5'h08,
      SRSEQ_H_DOWN = 5'h10
   } srseq_hstate_t;
endpackage

// ---- design/srseq_if.sv ----
// Link between the sequencer device and its host controller
`timescale 1ns/1ps
`default_nettype none
interface srseq_if;
   import srseq_pkg::*;
   logic sequence_trigger;
   logic driver_power_down;
   logic [SRSEQ_DRV_W-1:0] driver_inputs;
   logic [SRSEQ_OUTS-1:0] supply_enable_outputs;
   logic driver_active;
   modport device (
      input sequence_trigger,
      input driver_power_down,
      input driver_inputs,
      output supply_enable_outputs,
      output driver_active
   );
   modport host (
      output sequence_trigger,
      output driver_power_down,
      output driver_inputs,
      input supply_enable_outputs,
      input driver_active
   );
endinterface
`default_nettype wire

// ---- design/srseq_device.sv ----
// Sequencer device end: steps four supply enables on and off
`timescale 1ns/1ps
`default_nettype none
module srseq_device
#(
   parameter int STEP_CYC = srseq_pkg::SRSEQ_STEP_CYC
)
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   srseq_if.device link,
   output logic [srseq_pkg::SRSEQ_DRV_W-1:0] driver_stage_out,
   output logic busy_out
);
   import srseq_pkg::*;

   // Zero-length steps mean nothing; longer ones overflow the counter
   if (STEP_CYC < 1 || STEP_CYC >= (1 << SRSEQ_CNT_W))
   begin : g_bad_step
      $error("STEP_CYC out of range");
   end

   // Compare against the last count so a step lasts exactly STEP_CYC edges
   // Limitation: step time is fixed per build, not trimmed at run time
   localparam logic [SRSEQ_CNT_W-1:0] STEP_LAST = SRSEQ_CNT_W'(STEP_CYC - 1);

   // Enables are thermometer coded: every bit below the top set bit is set
   srseq_state_t state_ff;
   logic [SRSEQ_OUTS-1:0] en_ff;
   logic [SRSEQ_OUTS-1:0] en_up;
   logic [SRSEQ_OUTS-1:0] en_down;
   logic [SRSEQ_CNT_W-1:0] cnt_ff;
   logic sequence_trigger_d_ff;
   logic [SRSEQ_DRV_W-1:0] drv_ff;
   logic act_ff;
   logic sequence_trigger_rise;
   logic step_due;
   logic at_top;
   logic at_bottom;

   function automatic logic is_stepping(input srseq_state_t st);
      return (st == SRSEQ_RISE) || (st == SRSEQ_FALL);
   endfunction

   // Up: each enable takes its lower neighbour, bit 0 a one; down: its upper one, the top bit a zero
   for (genvar b = 0; b < SRSEQ_OUTS; b++)
   begin : g_step
      if (b == 0)
      begin : g_up_first
         assign en_up[b] = 1'b1;
      end
      else
      begin : g_up_next
         assign en_up[b] = en_ff[b-1];
      end
      if (b == SRSEQ_OUTS - 1)
      begin : g_down_last
         assign en_down[b] = 1'b0;
      end
      else
      begin : g_down_next
         assign en_down[b] = en_ff[b+1];
      end
   end

   // Full and empty are judged on the value the step is about to load
   assign at_top = (en_up == SRSEQ_ALL_ON);
   assign at_bottom = (en_down == SRSEQ_ALL_OFF);
   // A trigger held high for several cycles still counts once
   assign sequence_trigger_rise = link.sequence_trigger && !sequence_trigger_d_ff;
   assign step_due = (cnt_ff == STEP_LAST);

   // Edge detector resets to the idle low level, so reset makes no false edge
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         sequence_trigger_d_ff <= 1'b0;
      end
      else
      begin
         sequence_trigger_d_ff <= link.sequence_trigger;
      end
   end

   // First step also waits a full period after the trigger
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in || !is_stepping(state_ff) || step_due)
      begin
         cnt_ff <= '0;
      end
      else
      begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // Settled states wait for a trigger edge; stepping ones for the last step
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         state_ff <= SRSEQ_OFF;
      end
      else
      begin
         unique case (state_ff)
            SRSEQ_OFF:
            begin
               if (sequence_trigger_rise)
               begin
                  state_ff <= SRSEQ_RISE;
               end
            end
            SRSEQ_RISE:
            begin
               // Triggers are not looked at until the order has finished
               if (step_due && at_top)
               begin
                  state_ff <= SRSEQ_ON;
               end
            end
            SRSEQ_ON:
            begin
               if (sequence_trigger_rise)
               begin
                  state_ff <= SRSEQ_FALL;
               end
            end
            SRSEQ_FALL:
            begin
               if (step_due && at_bottom)
               begin
                  state_ff <= SRSEQ_OFF;
               end
            end
         endcase
      end
   end

   // Only the stepping states move the enables, one bit per step
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         en_ff <= SRSEQ_ALL_OFF;
      end
      else if (step_due && state_ff == SRSEQ_RISE)
      begin
         en_ff <= en_up;
      end
      else if (step_due && state_ff == SRSEQ_FALL)
      begin
         en_ff <= en_down;
      end
   end

   // Status tracks the pin one cycle late, like the data stage
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         act_ff <= 1'b0;
      end
      else
      begin
         act_ff <= !link.driver_power_down;
      end
   end

   // Driver stage follows inputs only while not powered down
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         drv_ff <= '0;
      end
      else if (link.driver_power_down)
      begin
         drv_ff <= '0;
      end
      else
      begin
         drv_ff <= link.driver_inputs;
      end
   end

   // Busy lags the state by a cycle; it is the only sign of ignored triggers
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         busy_out <= 1'b0;
      end
      else
      begin
         busy_out <= is_stepping(state_ff);
      end
   end

   // Link outputs come straight from flip-flops
   assign link.supply_enable_outputs = en_ff;
   assign link.driver_active = act_ff;
   assign driver_stage_out = drv_ff;
endmodule
`default_nettype wire

// ---- design/srseq_host.sv ----
// Host end: drives trigger and driver pins in the safe power order
`timescale 1ns/1ps
`default_nettype none
module srseq_host
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   srseq_if.host link,
   input wire logic power_up_req_in,
   input wire logic power_down_req_in,
   input wire logic [srseq_pkg::SRSEQ_DRV_W-1:0] drive_data_in,
   input wire logic shutdown_req_in,
   output logic rails_up_out,
   output logic rails_down_out
);
   import srseq_pkg::*;

   srseq_hstate_t st_ff;
   logic sequence_trigger_ff;
   logic pd_ff;
   logic [SRSEQ_DRV_W-1:0] drv_ff;

   // Pins stay at safe levels outside the up state
   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         st_ff <= SRSEQ_H_IDLE;
         sequence_trigger_ff <= 1'b0;
         pd_ff <= 1'b0;
         drv_ff <= '0;
      end
      else
      begin
         sequence_trigger_ff <= 1'b0;
         unique case (st_ff)
            SRSEQ_H_IDLE:
            begin
               pd_ff <= 1'b0;
               drv_ff <= '0;
               if (power_up_req_in && link.supply_enable_outputs == SRSEQ_ALL_OFF)
               begin
                  sequence_trigger_ff <= 1'b1;
                  st_ff <= SRSEQ_H_WAIT_ON;
               end
            end
            SRSEQ_H_WAIT_ON:
            begin
               if (link.supply_enable_outputs == SRSEQ_ALL_ON)
               begin
                  st_ff <= SRSEQ_H_UP;
               end
            end
            SRSEQ_H_UP:
            begin
               pd_ff <= shutdown_req_in;
               drv_ff <= drive_data_in;
               if (power_down_req_in)
               begin
                  pd_ff <= 1'b0;
                  drv_ff <= '0;
                  sequence_trigger_ff <= 1'b1;
                  st_ff <= SRSEQ_H_WAIT_OFF;
               end
            end
            SRSEQ_H_WAIT_OFF:
            begin
               if (link.supply_enable_outputs == SRSEQ_ALL_OFF)
               begin
                  st_ff <= SRSEQ_H_IDLE;
               end
            end
            SRSEQ_H_DOWN:
            begin
               st_ff <= SRSEQ_H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (!rstn_in)
      begin
         rails_up_out <= 1'b0;
         rails_down_out <= 1'b0;
      end
      else
      begin
         rails_up_out <= (link.supply_enable_outputs == SRSEQ_ALL_ON);
         rails_down_out <= (link.supply_enable_outputs == SRSEQ_ALL_OFF);
      end
   end

   assign link.sequence_trigger = sequence_trigger_ff;
   assign link.driver_power_down = pd_ff;
   assign link.driver_inputs = drv_ff;
endmodule
`default_nettype wire

// ---- tb/srseq_sva.sv ----
// Assertion checker for the sequencer link
`timescale 1ns/1ps
`default_nettype none
module srseq_sva
import srseq_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic sequence_trigger,
   input wire logic driver_power_down,
   input wire logic [SRSEQ_DRV_W-1:0] driver_inputs,
   input wire logic [SRSEQ_OUTS-1:0] supply_enable_outputs,
   input wire logic driver_active
);
   wire logic [3:0] en;
   assign en = supply_enable_outputs;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rstn_in);
   // Delays assume the bench's step of 5 cycles
   sequence s_rise;
      ##5 $rose(en[1]) ##5 $rose(en[2]) ##5 $rose(en[3]);
   endsequence
   sequence s_fall;
      ##5 $fell(en[2]) ##5 $fell(en[1]) ##5 $fell(en[0]);
   endsequence
   chk_reset_all_off: assert property ($rose(rstn_in) |-> en == 4'h0)
      else $error("enables not low after reset");
   chk_step_order: assert property ($changed(en) |->
      en == {$past(en[2:0]), 1'b1} || en == {1'b0, $past(en[3:1])})
      else $error("enable step out of order");
   chk_on_start: assert property ($rose(sequence_trigger) && en == 4'h0 &&
      $past(en, 6) == 4'h0 |-> (en == 4'h0) [*5] ##[1:3] en == 4'h1)
      else $error("first enable late or early");
   chk_rise_run: assert property ($rose(en[0]) |-> s_rise)
      else $error("rise steps broken");
   chk_fall_run: assert property ($fell(en[3]) |-> s_fall)
      else $error("fall steps broken");
   chk_pd_off: assert property (driver_power_down |=> !driver_active)
      else $error("driver active in power-down");
   chk_pd_on: assert property (!driver_power_down [*2] |=> driver_active)
      else $error("driver idle without power-down");
   chk_off_quiet: assert property ($rose(sequence_trigger) && en == 4'hF |->
      !driver_power_down && driver_inputs == 16'h0000)
      else $error("pins not low at power-off");
endmodule
`default_nettype wire

// ---- tb/srseq_tb.sv ----
// Self-checking bench: host and sequencer joined over their link
`timescale 1ns/1ps
`default_nettype none
module srseq_tb;
   import srseq_pkg::*;
   logic sys_clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic up_req = 1'b0;
   logic dn_req = 1'b0;
   logic sd_req = 1'b0;
   logic [15:0] data = 16'h0000;
   logic [15:0] stage;
   logic rails_up;
   logic rails_down;
   logic busy;
   localparam int STEP = 5;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   srseq_if link();
   srseq_device #(.STEP_CYC(STEP)) i_srseq_device (.sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in), .link(link), .driver_stage_out(stage), .busy_out(busy));
   srseq_host i_srseq_host (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .link(link),
      .power_up_req_in(up_req), .power_down_req_in(dn_req), .drive_data_in(data),
      .shutdown_req_in(sd_req), .rails_up_out(rails_up), .rails_down_out(rails_down));
   srseq_sva i_srseq_sva (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
      .sequence_trigger(link.sequence_trigger), .driver_power_down(link.driver_power_down),
      .driver_inputs(link.driver_inputs), .supply_enable_outputs(link.supply_enable_outputs),
      .driver_active(link.driver_active));
   always #5 sys_clk_in = ~sys_clk_in;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function automatic logic [3:0] nxt_step(input logic [3:0] v, input logic up);
      return up ? {v[2:0], 1'b1} : {1'b0, v[3:1]};
   endfunction
   // Follows one whole order, checking each step and the spacing between steps
   task automatic watch(input logic up);
      logic [3:0] prev;
      int last;
      prev = link.supply_enable_outputs;
      last = -1;
      for (int i = 0; i < 200 && prev !== (up ? 4'hF : 4'h0); i++)
      begin
         @(negedge sys_clk_in);
         if (link.supply_enable_outputs !== prev)
         begin
            check(link.supply_enable_outputs, nxt_step(prev, up));
            check(busy, 1'b1);
            if (last >= 0)
               check(32'(i - last), 32'(STEP));
            last = i;
            prev = link.supply_enable_outputs;
         end
      end
      check(prev, up ? 4'hF : 4'h0);
   endtask
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         errors++;
         results();
      end
   end
   initial
   begin
      void'($urandom(32'h297D));
      repeat (10) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      @(negedge sys_clk_in);
      check(link.supply_enable_outputs, 4'h0);
      repeat (3) @(negedge sys_clk_in);
      check(rails_down, 1'b1);
      for (int k = 0; k < 4; k++)
      begin
         // Data offered early must stay off the pins until rails are up
         @(posedge sys_clk_in);
         data <= 16'($urandom);
         sd_req <= k[0];
         up_req <= 1'b1;
         repeat (3) @(negedge sys_clk_in);
         check({link.driver_power_down, link.driver_inputs}, 17'h0);
         watch(1'b1);
         @(posedge sys_clk_in);
         up_req <= 1'b0;
         repeat (4) @(negedge sys_clk_in);
         check(rails_up, 1'b1);
         check(busy, 1'b0);
         check(stage, k[0] ? 16'h0000 : data);
         check(link.driver_active, !k[0]);
         @(posedge sys_clk_in);
         dn_req <= 1'b1;
         watch(1'b0);
         check(link.driver_inputs, 16'h0000);
         @(posedge sys_clk_in);
         dn_req <= 1'b0;
         repeat (8) @(negedge sys_clk_in);
         check(rails_down, 1'b1);
         check(busy, 1'b0);
      end
      results();
   end
endmodule
`default_nettype wire
